// ---- logic/cxs_defs.svh ----
// Purpose: named constants of the comm extended setup register bank
// Assumes: word addressing on the register bus, 16-bit setup words
// Notes:   definitions only
`ifndef CXS_DEFS_SVH
`define CXS_DEFS_SVH

// ---------------------------------------------------------------
// register word indices (byte address is four times the index)
// ---------------------------------------------------------------
`define CXS_IDX_SETUP_TWO   3'h0
`define CXS_IDX_SETUP_THREE 3'h1
`define CXS_IDX_RSVD_39     3'h2
`define CXS_IDX_ALIAS_HIGH  3'h3
`define CXS_IDX_ALIAS_SEL   3'h4
`define CXS_IDX_STATUS      3'h5

// ---------------------------------------------------------------
// reset values and the alias high limit
// ---------------------------------------------------------------
`define CXS_RST_SETUP_TWO   16'h0000
`define CXS_RST_SETUP_THREE 16'h3010
`define CXS_RST_ALIAS_HIGH  16'h0000
`define CXS_RST_ALIAS_SEL   2'h0
`define CXS_ALIAS_HIGH_MAX  16'h00FF

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CXS_BIT_DEV_RAW     14
`define CXS_BIT_OUT_INIT    0
`define CXS_BIT_LATCH_SPLIT 5
`define CXS_BIT_TQ_KEEP     7
`define CXS_BIT_FOLLOW_EXCL 11

// ---------------------------------------------------------------
// link state machine codes
// ---------------------------------------------------------------
`define CXS_ESM_PREOP       4'h2

`endif

// ---- logic/cxs_pkg.sv ----
// Purpose: shared types of the comm extended setup register bank
// Assumes: nothing beyond the constants header
// Notes:   alias source codes follow the selection parameter values
package cxs_pkg;
  typedef logic [15:0] cxs_word_t;
  typedef logic signed [31:0] cxs_pos_t;
  typedef enum logic [1:0] {
    CXS_SRC_SWITCH = 2'h0,
    CXS_SRC_SII    = 2'h1,
    CXS_SRC_MAKER  = 2'h2
  } cxs_alias_src_t;
endpackage

// ---- logic/cxs_cfg_if.sv ----
// Purpose: carries setup fields and drive inputs to the apply logic
// Assumes: one clock domain, all signals combinational here
// Notes:   results flow back to the register bank, which registers them
interface cxs_cfg_if;
  import cxs_pkg::*;
  cxs_word_t      setup_two;
  cxs_word_t      setup_three;
  cxs_word_t      alias_high;
  cxs_alias_src_t alias_sel;
  cxs_pos_t       cmd_filt;
  cxs_pos_t       cmd_raw;
  cxs_pos_t       act_pos;
  cxs_word_t      rise_time;
  cxs_word_t      fall_time;
  cxs_word_t      tq_set;
  logic           servo_off;
  logic           torque_lim;
  logic           speed_lim;
  logic           cst_mode;
  logic           follow_base;
  logic [7:0]     rot_sw;
  cxs_word_t      sii_alias;
  logic           out_cmd;
  logic           out_now;
  logic           shut_active;
  cxs_pos_t       deviation;
  cxs_word_t      rise_corr;
  cxs_word_t      fall_corr;
  cxs_word_t      tq_internal;
  logic           follows;
  cxs_word_t      alias_word;
  logic           out_next;

  modport bank (output setup_two, setup_three, alias_high, alias_sel, cmd_filt, cmd_raw,
                act_pos, rise_time, fall_time, tq_set, servo_off, torque_lim, speed_lim,
                cst_mode, follow_base, rot_sw, sii_alias, out_cmd, out_now, shut_active,
                input deviation, rise_corr, fall_corr, tq_internal, follows, alias_word,
                out_next);
  modport apply (input setup_two, setup_three, alias_high, alias_sel, cmd_filt, cmd_raw,
                 act_pos, rise_time, fall_time, tq_set, servo_off, torque_lim, speed_lim,
                 cst_mode, follow_base, rot_sw, sii_alias, out_cmd, out_now, shut_active,
                 output deviation, rise_corr, fall_corr, tq_internal, follows, alias_word,
                 out_next);
endinterface

// ---- logic/cxs_apply.sv ----
// Purpose: turns the setup fields into drive-side effects
// Assumes: all inputs stable within the cycle, bank registers results
// Notes:   purely combinational
`include "cxs_defs.svh"

module cxs_apply
  import cxs_pkg::*;
(
  // configuration and results
  cxs_cfg_if.apply p
);

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  wire use_raw     = p.setup_two[`CXS_BIT_DEV_RAW];
  wire out_init    = p.setup_three[`CXS_BIT_OUT_INIT];
  wire latch_split = p.setup_three[`CXS_BIT_LATCH_SPLIT];
  wire tq_keep     = p.setup_three[`CXS_BIT_TQ_KEEP];
  wire follow_excl = p.setup_three[`CXS_BIT_FOLLOW_EXCL];

  // deviation source: filtered or unfiltered command
  assign p.deviation = (use_raw ? p.cmd_raw : p.cmd_filt) - p.act_pos;

  // shut-down either freezes the output or forces the zero command
  assign p.out_next = p.shut_active ? (out_init ? 1'b0 : p.out_now)
                                    : p.out_cmd;

  // falling edges share the rising time unless split
  assign p.rise_corr = p.rise_time;
  assign p.fall_corr = latch_split ? p.fall_time : p.rise_time;

  // while servo off the offset is cleared unless kept updated
  assign p.tq_internal = (p.servo_off && !tq_keep) ? 16'h0000 : p.tq_set;

  // limiting blocks the follow flag only when the bit is clear
  wire limit_hit = p.torque_lim || (p.cst_mode && p.speed_lim);
  assign p.follows = p.follow_base && (follow_excl || !limit_hit);

  // switch low byte plus parameter high byte, else the eeprom value
  assign p.alias_word = (p.alias_sel == CXS_SRC_SWITCH) ? {p.alias_high[7:0], p.rot_sw}
                                                   : p.sii_alias;

endmodule

// ---- logic/cxs_regs.sv ----
// Purpose: comm extended setup register bank with Avalon-MM slave port
// Assumes: 125 MHz sys_clk, nrst asynchronous active low
// Notes:   every access takes two cycles; unmapped reads give zero

`include "cxs_defs.svh"

module cxs_regs
  import cxs_pkg::*;
(
  // clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // avalon-mm slave
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // position path
  input  wire cxs_pos_t    cmd_filt,
  input  wire cxs_pos_t    cmd_raw,
  input  wire cxs_pos_t    act_pos,
  output cxs_pos_t         deviation,
  // general output and link
  input  wire logic        out_cmd,
  input  wire logic [3:0]  esm_state,
  input  wire logic        comm_down,
  output logic             general_output_one,
  // latch correction
  input  wire cxs_word_t   latch_rise_correction_time,
  input  wire cxs_word_t   latch_fall_correction_time,
  output cxs_word_t        rise_corr,
  output cxs_word_t        fall_corr,
  // torque offset
  input  wire cxs_word_t   tq_set,
  input  wire logic        servo_off,
  output cxs_word_t        tq_internal,
  // follow status
  input  wire logic        follow_base,
  input  wire logic        torque_lim,
  input  wire logic        speed_lim,
  input  wire logic        cst_mode,
  output logic             drive_follows,
  // station alias
  input  wire logic [7:0]  rotary_switch,
  input  wire cxs_word_t   sii_alias,
  output cxs_word_t        station_alias
);

  // ---------------------------------------------------------------
  // storage and helpers
  // ---------------------------------------------------------------
  cxs_word_t      setup_two_reg;
  cxs_word_t      setup_three_reg;
  cxs_word_t      alias_high_reg;
  cxs_alias_src_t alias_sel_reg;
  logic           wait_reg;
  logic [31:0]    rdata_reg;
  logic           past_preop_reg;
  logic           gp_out_reg;
  cxs_pos_t       dev_reg;
  cxs_word_t      rise_reg;
  cxs_word_t      fall_reg;
  cxs_word_t      tq_reg;
  logic           follow_reg;
  cxs_word_t      alias_reg;
  logic [7:0]     rot_meta_reg;
  logic [7:0]     rot_sync_reg;

  cxs_cfg_if cfg ();

  // merge write data into a 16-bit word under the two low byte lanes
  function automatic cxs_word_t merge16(input cxs_word_t old, input logic [31:0] wd,
                                        input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ---------------------------------------------------------------
  // rotary switch synchroniser
  // ---------------------------------------------------------------
  // the switch is a pin; only the second stage is read downstream
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rot_meta_reg <= 8'h00;
      rot_sync_reg <= 8'h00;
    end else if (clk_en) begin
      rot_meta_reg <= rotary_switch;
      rot_sync_reg <= rot_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // the request is accepted at the edge where waitrequest is seen low
  wire req       = avs_read || avs_write;
  wire wr_fire   = avs_write && !wait_reg;
  wire hit_two   = avs_address == `CXS_IDX_SETUP_TWO;
  wire hit_three = avs_address == `CXS_IDX_SETUP_THREE;
  wire hit_ahigh = avs_address == `CXS_IDX_ALIAS_HIGH;
  wire hit_asel  = avs_address == `CXS_IDX_ALIAS_SEL;

  wire cxs_word_t two_next   = merge16(setup_two_reg, avs_writedata, avs_byteenable);
  wire cxs_word_t three_next = merge16(setup_three_reg, avs_writedata, avs_byteenable);
  wire cxs_word_t ahigh_new  = merge16(alias_high_reg, avs_writedata, avs_byteenable);
  // values beyond one byte are refused so the high byte stays meaningful
  wire ahigh_ok = ahigh_new <= `CXS_ALIAS_HIGH_MAX;
  // selection code 3 is not defined and is refused
  wire asel_ok  = avs_byteenable[0] && (avs_writedata[1:0] != 2'h3);

  // status word: alias in the low half, live flags above
  wire [31:0] status_word = {12'h000, follow_reg, gp_out_reg, past_preop_reg,
                             cfg.shut_active, alias_reg};

  // read mux; reserved word and unmapped addresses read zero
  wire [31:0] rd_mux =
      hit_two   ? {16'h0000, setup_two_reg}   :
      hit_three ? {16'h0000, setup_three_reg} :
      hit_ahigh ? {16'h0000, alias_high_reg}  :
      hit_asel  ? {30'h00000000, alias_sel_reg} :
      (avs_address == `CXS_IDX_STATUS) ? status_word : 32'h00000000;

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // one wait cycle per access; read data is captured while waiting
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else if (clk_en) begin
      wait_reg <= !(req && wait_reg);
      if (avs_read && wait_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // setup words
  // ---------------------------------------------------------------
  // words are stored whole, reserved bits included, as the host wrote them
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      setup_two_reg   <= `CXS_RST_SETUP_TWO;
      setup_three_reg <= `CXS_RST_SETUP_THREE;
      alias_high_reg  <= `CXS_RST_ALIAS_HIGH;
      alias_sel_reg   <= cxs_alias_src_t'(`CXS_RST_ALIAS_SEL);
    end else if (clk_en && wr_fire) begin
      if (hit_two) begin
        setup_two_reg <= two_next;
      end
      if (hit_three) begin
        setup_three_reg <= three_next;
      end
      if (hit_ahigh && ahigh_ok) begin
        alias_high_reg <= ahigh_new;
      end
      if (hit_asel && asel_ok) begin
        alias_sel_reg <= cxs_alias_src_t'(avs_writedata[1:0]);
      end
    end
  end

  // ---------------------------------------------------------------
  // link tracking
  // ---------------------------------------------------------------
  // remember that the link got past pre-operational; frozen while down
  // so a shut-down keeps the decision taken before it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      past_preop_reg <= 1'b0;
    end else if (clk_en && !comm_down) begin
      past_preop_reg <= esm_state > `CXS_ESM_PREOP;
    end
  end

  // ---------------------------------------------------------------
  // apply logic hookup
  // ---------------------------------------------------------------
  assign cfg.setup_two   = setup_two_reg;
  assign cfg.setup_three = setup_three_reg;
  assign cfg.alias_high  = alias_high_reg;
  assign cfg.alias_sel   = alias_sel_reg;
  assign cfg.cmd_filt    = cmd_filt;
  assign cfg.cmd_raw     = cmd_raw;
  assign cfg.act_pos     = act_pos;
  assign cfg.rise_time   = latch_rise_correction_time;
  assign cfg.fall_time   = latch_fall_correction_time;
  assign cfg.tq_set      = tq_set;
  assign cfg.servo_off   = servo_off;
  assign cfg.torque_lim  = torque_lim;
  assign cfg.speed_lim   = speed_lim;
  assign cfg.cst_mode    = cst_mode;
  assign cfg.follow_base = follow_base;
  assign cfg.rot_sw      = rot_sync_reg;
  assign cfg.sii_alias   = sii_alias;
  assign cfg.out_cmd     = out_cmd;
  assign cfg.out_now     = gp_out_reg;
  assign cfg.shut_active = comm_down && past_preop_reg;

  cxs_apply u_apply (
    .p (cfg.apply)
  );

  // ---------------------------------------------------------------
  // registered results
  // ---------------------------------------------------------------
  // one cycle of latency on every result keeps outputs glitch free
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gp_out_reg <= 1'b0;
      dev_reg    <= 32'sh00000000;
      rise_reg   <= 16'h0000;
      fall_reg   <= 16'h0000;
      tq_reg     <= 16'h0000;
      follow_reg <= 1'b0;
      alias_reg  <= 16'h0000;
    end else if (clk_en) begin
      gp_out_reg <= cfg.out_next;
      dev_reg    <= cfg.deviation;
      rise_reg   <= cfg.rise_corr;
      fall_reg   <= cfg.fall_corr;
      tq_reg     <= cfg.tq_internal;
      follow_reg <= cfg.follows;
      alias_reg  <= cfg.alias_word;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_readdata       = rdata_reg;
  assign avs_waitrequest    = wait_reg;
  assign deviation          = dev_reg;
  assign general_output_one = gp_out_reg;
  assign rise_corr          = rise_reg;
  assign fall_corr          = fall_reg;
  assign tq_internal        = tq_reg;
  assign drive_follows      = follow_reg;
  assign station_alias      = alias_reg;

endmodule

// ---- dv/cxs_host.sv ----
// Purpose: avalon-mm master standing in for the configuring fieldbus master
// Assumes: one request at a time, both data lanes enabled
// Notes:   reserved setup bits always go out at their fixed levels
`include "cxs_defs.svh"
module cxs_host
  import cxs_pkg::*;
(
  // clock
  input  wire logic        sys_clk,
  // avalon-mm master side
  output logic      [2:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  // raised when the slave never answers
  output logic             stuck
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus from time zero
  initial begin
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    stuck = 1'b0;
  end
  // one transfer, held until waitrequest is seen low; bounded so a dead slave ends the run
  task automatic xfer(input logic we, input logic [2:0] a, input cxs_word_t d,
                      output cxs_word_t q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_read <= !we;
    avs_write <= we;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest && n < 40);
    if (avs_waitrequest) stuck <= 1'b1;
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // setup words with their reserved bits forced
  task automatic w2(input cxs_word_t d);
    cxs_word_t q;
    xfer(1'b1, `CXS_IDX_SETUP_TWO, d & 16'h4000, q);
  endtask
  task automatic w3(input cxs_word_t d);
    cxs_word_t q;
    xfer(1'b1, `CXS_IDX_SETUP_THREE, (d & 16'h08A1) | 16'h3010, q);
  endtask
endmodule

// ---- dv/cxs_regs_checker.sv ----
// Purpose: bus and drive-path assertions for the setup bank
// Assumes: full-lane writes, esm_state steady across a link loss
// Notes:   shadows mirror the stored setup words
`include "cxs_defs.svh"
module cxs_regs_checker
  import cxs_pkg::*;
(
  // bus
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [2:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // drive path
  input wire cxs_pos_t    cmd_filt,
  input wire cxs_pos_t    cmd_raw,
  input wire cxs_pos_t    act_pos,
  input wire cxs_pos_t    deviation,
  input wire logic [3:0]  esm_state,
  input wire logic        comm_down,
  input wire logic        general_output_one,
  input wire cxs_word_t   latch_rise_correction_time,
  input wire cxs_word_t   latch_fall_correction_time,
  input wire cxs_word_t   rise_corr,
  input wire cxs_word_t   fall_corr,
  input wire cxs_word_t   tq_set,
  input wire logic        servo_off,
  input wire cxs_word_t   tq_internal,
  input wire logic        follow_base,
  input wire logic        torque_lim,
  input wire logic        speed_lim,
  input wire logic        cst_mode,
  input wire logic        drive_follows
);
  timeunit 1ns;
  timeprecision 1ns;
  cxs_word_t s2, s3;
  logic      wr_ok, raw_sel, split, keep, excl, zero_out;
  // field taps of the shadows
  assign wr_ok = avs_write && !avs_waitrequest;
  assign raw_sel = s2[14];
  assign split = s3[5];
  assign keep = s3[7];
  assign excl = s3[11];
  assign zero_out = s3[0];
  // shadows load at the edge that completes a write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s2 <= `CXS_RST_SETUP_TWO;
      s3 <= `CXS_RST_SETUP_THREE;
    end else if (wr_ok && avs_address == `CXS_IDX_SETUP_TWO) begin
      s2 <= avs_writedata[15:0];
    end else if (wr_ok && avs_address == `CXS_IDX_SETUP_THREE) begin
      s3 <= avs_writedata[15:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("request not answered");
  property p_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_pulse: assert property (p_pulse) else $error("waitrequest low too long");
  property p_rd; avs_read && !avs_waitrequest && avs_address < 3'h3 |-> avs_readdata ==
    {16'h0, avs_address == 3'h0 ? s2 : avs_address == 3'h1 ? s3 : 16'h0}; endproperty
  a_rd: assert property (p_rd) else $error("stored word read back wrong");
  property p_dev; $past(nrst) |-> deviation ==
    ($past(raw_sel) ? $past(cmd_raw) : $past(cmd_filt)) - $past(act_pos); endproperty
  a_dev: assert property (p_dev) else $error("deviation source wrong");
  property p_corr; $past(nrst) |-> rise_corr == $past(latch_rise_correction_time) &&
    fall_corr == ($past(split) ? $past(latch_fall_correction_time)
                               : $past(latch_rise_correction_time)); endproperty
  a_corr: assert property (p_corr) else $error("latch correction wrong");
  property p_tq; $past(nrst) |-> tq_internal ==
    (($past(servo_off) && !$past(keep)) ? 16'h0 : $past(tq_set)); endproperty
  a_tq: assert property (p_tq) else $error("torque offset wrong");
  property p_fol; $past(nrst) |-> drive_follows == ($past(follow_base) && ($past(excl) ||
    !($past(torque_lim) || ($past(cst_mode) && $past(speed_lim))))); endproperty
  a_fol: assert property (p_fol) else $error("follow status wrong");
  property p_out; $past(comm_down) && $past(comm_down, 2) && $past(esm_state, 2) > 4'h2
    |-> ($past(zero_out) ? !general_output_one : $stable(general_output_one)); endproperty
  a_out: assert property (p_out) else $error("output on link loss wrong");
endmodule
bind cxs_regs cxs_regs_checker u_chk (.sys_clk, .nrst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .cmd_filt, .cmd_raw, .act_pos, .deviation,
  .esm_state, .comm_down, .general_output_one, .latch_rise_correction_time,
  .latch_fall_correction_time, .rise_corr, .fall_corr, .tq_set, .servo_off, .tq_internal,
  .follow_base, .torque_lim, .speed_lim, .cst_mode, .drive_follows);

// ---- dv/tb_top.sv ----
// Purpose: self-checking bench of the setup register bank
// Assumes: checker bound separately, host model drives the bus
// Notes:   clock enable dropped once to check that state freezes
`include "cxs_defs.svh"
module tb_top
  import cxs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, nrst, avs_read, avs_write, avs_waitrequest, stuck, comm_down;
  logic        out_cmd, servo_off, follow_base, torque_lim, speed_lim, cst_mode, clk_en;
  logic        general_output_one, drive_follows;
  logic [2:0]  avs_address;
  logic [3:0]  avs_byteenable, esm_state;
  logic [7:0]  rotary_switch;
  logic [31:0] avs_writedata, avs_readdata;
  cxs_pos_t    cmd_filt, cmd_raw, act_pos, deviation;
  cxs_word_t   rise_t, fall_t, rise_corr, fall_corr, tq_set, tq_internal;
  cxs_word_t   sii_alias, station_alias, q;
  int          miscompares, n_checks;
  cxs_regs DUT (.sys_clk, .nrst, .clk_en, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cmd_filt, .cmd_raw,
    .act_pos, .deviation, .out_cmd, .esm_state, .comm_down, .general_output_one,
    .latch_rise_correction_time(rise_t), .latch_fall_correction_time(fall_t), .rise_corr,
    .fall_corr, .tq_set, .servo_off, .tq_internal, .follow_base, .torque_lim, .speed_lim,
    .cst_mode, .drive_follows, .rotary_switch, .sii_alias, .station_alias);
  cxs_host host (.sys_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .stuck);
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // reset values, reserved and unmapped words, plain store
  task automatic t_regs;
    for (int i = 0; i < 8; i++) begin
      host.xfer(1'b0, 3'(i), 16'h0, q);
      chk("reset word", q, (i == 1) ? 32'h3010 : 32'h0);
    end
    host.xfer(1'b1, `CXS_IDX_RSVD_39, 16'hFFFF, q);
    host.xfer(1'b0, `CXS_IDX_RSVD_39, 16'h0, q);
    chk("reserved word", q, 32'h0);
    host.w3(16'h38B1);
    host.xfer(1'b0, `CXS_IDX_SETUP_THREE, 16'h0, q);
    chk("setup three", q, 32'h38B1);
  endtask
  task automatic t_dev;
    for (int b = 0; b < 2; b++) begin
      host.w2(b ? 16'h4000 : 16'h0);
      tick(3);
      chk("deviation", deviation, b ? 32'h64 : 32'hFFFF_FFF6);
    end
  endtask
  task automatic t_latch;
    for (int b = 0; b < 2; b++) begin
      host.w3(b ? 16'h3030 : 16'h3010);
      tick(3);
      chk("rise corr", rise_corr, 32'h11);
      chk("fall corr", fall_corr, b ? 32'h22 : 32'h11);
    end
  endtask
  task automatic t_tq;
    for (int i = 0; i < 4; i++) begin
      servo_off <= i[0];
      host.w3(i[1] ? 16'h3090 : 16'h3010);
      tick(3);
      chk("torque offset", tq_internal, (i[0] && !i[1]) ? 32'h0 : 32'h123);
    end
    servo_off <= 1'b0;
  endtask
  task automatic t_follow;
    for (int i = 0; i < 16; i++) begin
      torque_lim <= i[0];
      speed_lim <= i[1];
      cst_mode <= i[2];
      host.w3(i[3] ? 16'h3810 : 16'h3010);
      tick(3);
      chk("follows", drive_follows, i[3] || !(i[0] || (i[2] && i[1])));
    end
    follow_base <= 1'b0;
    tick(3);
    chk("follows base", drive_follows, 32'h0);
  endtask
  // link loss past pre-operational: hold, then zero; below it the output tracks
  task automatic t_out;
    esm_state <= 4'h4;
    out_cmd <= 1'b1;
    host.w3(16'h3010);
    tick(3);
    comm_down <= 1'b1;
    out_cmd <= 1'b0;
    tick(4);
    chk("output hold", general_output_one, 32'h1);
    host.w3(16'h3011);
    tick(3);
    chk("output zero", general_output_one, 32'h0);
    comm_down <= 1'b0;
    esm_state <= 4'h1;
    tick(3);
    comm_down <= 1'b1;
    out_cmd <= 1'b1;
    tick(3);
    chk("output early", general_output_one, 32'h1);
    comm_down <= 1'b0;
  endtask
  // enable low must hold the output although the command moves
  task automatic t_freeze;
    clk_en <= 1'b0;
    out_cmd <= 1'b0;
    tick(3);
    chk("frozen output", general_output_one, 32'h1);
    clk_en <= 1'b1;
    tick(3);
    chk("thawed output", general_output_one, 32'h0);
  endtask
  task automatic t_alias;
    rotary_switch <= 8'h3C;
    host.xfer(1'b1, `CXS_IDX_ALIAS_HIGH, 16'h00A5, q);
    host.xfer(1'b1, `CXS_IDX_ALIAS_HIGH, 16'h0100, q);
    host.xfer(1'b0, `CXS_IDX_ALIAS_HIGH, 16'h0, q);
    chk("alias high", q, 32'hA5);
    tick(5);
    chk("alias switch", station_alias, 32'hA53C);
    host.xfer(1'b1, `CXS_IDX_ALIAS_SEL, 16'h1, q);
    tick(3);
    chk("alias sii", station_alias, 32'h7E57);
    host.xfer(1'b1, `CXS_IDX_ALIAS_SEL, 16'h3, q);
    host.xfer(1'b0, `CXS_IDX_ALIAS_SEL, 16'h0, q);
    chk("alias sel kept", q, 32'h1);
    host.xfer(1'b1, `CXS_IDX_ALIAS_SEL, 16'h0, q);
    tick(3);
    chk("alias switch again", station_alias, 32'hA53C);
    host.xfer(1'b1, `CXS_IDX_ALIAS_SEL, 16'h2, q);
    tick(3);
    chk("alias code two", station_alias, 32'h7E57);
  endtask
  // a dead slave ends the run
  always @(posedge stuck) begin
    miscompares++;
    print_verdict;
  end
  initial begin
    nrst = 1'b0;
    {comm_down, out_cmd, servo_off, torque_lim, speed_lim, cst_mode} = 6'h0;
    follow_base = 1'b1;
    clk_en = 1'b1;
    esm_state = 4'h0;
    rotary_switch = 8'h0;
    cmd_filt = 32'h5A;
    cmd_raw = 32'hC8;
    act_pos = 32'h64;
    rise_t = 16'h0011;
    fall_t = 16'h0022;
    tq_set = 16'h0123;
    sii_alias = 16'h7E57;
    miscompares = 0;
    n_checks = 0;
    tick(6);
    nrst <= 1'b1;
    t_regs;
    t_dev;
    t_latch;
    t_tq;
    t_follow;
    t_out;
    t_freeze;
    t_alias;
    print_verdict;
  end
endmodule
